// File: logic/regfile_pkg.sv
// constants, types and register map for the banked register file addressing
// assumes a single system clock; the processor core issues one access at a time
// Behaviour
// - option byte bit 3 selects stack width
// - wide stack pointer is high:low byte pair
// - upper high-byte bits ignored per RAM size
// - wide stack bank, group, register from pointer
// - wide stack always lands in RAM shadows
// - narrow stack uses low byte, bank 0
// - narrow mode leaves high byte as user data
// - group select nibble picks working group
// - bank nibble picks active bank, zero normal
// - banks D and F swap low sixteen registers
// - bank/group register at FDh, resets zero
// - push pre-decrements, pop post-increments
// - pointer addresses newest, lowest stack byte
// - call saves PC, interrupt PC and flags
// - F0h-FFh reach bank 0 controls, except wide stack
package regfile_pkg;
  localparam logic [7:0] GROUP_SELECT_ADDR = 8'hFD;
  localparam logic [7:0] SP_HIGH_ADDR = 8'hFE;
  localparam logic [7:0] SP_LOW_ADDR = 8'hFF;
  localparam logic [3:0] CONTROL_GROUP = 4'hF;
  localparam logic [7:0] PORT_LAST_ADDR = 8'h03;
  localparam logic [3:0] BANK_NORMAL = 4'h0;
  localparam logic [3:0] BANK_LAST_RAM = 4'h3;
  localparam logic [3:0] BANK_D = 4'hD;
  localparam logic [3:0] BANK_F = 4'hF;
  localparam int WIDE_STACK_BIT = 3;
  localparam logic [7:0] SP_HIGH_KEEP_1K = 8'h03;
  localparam logic [7:0] SP_HIGH_KEEP_512 = 8'h07;
  localparam logic [7:0] GROUP_SELECT_RESET = 8'h00;
  localparam logic [7:0] SP_HIGH_RESET = 8'h00;
  localparam logic [7:0] SP_LOW_RESET = 8'h00;
  localparam int RAM_AW = 10;
  localparam int RAM_DEPTH = 1024;
  localparam logic [1:0] CALL_LAST_BYTE = 2'h1;
  localparam logic [1:0] INTR_LAST_BYTE = 2'h2;

  typedef enum logic [3:0]
  {
    S_IDLE = 4'h1,
    S_ISSUE = 4'h2,
    S_WAIT = 4'h4,
    S_CAPTURE = 4'h8
  } seq_state_e;

  typedef enum logic [1:0]
  {
    CMD_PUSH = 2'h0,
    CMD_POP = 2'h1,
    CMD_CALL = 2'h2,
    CMD_INTR = 2'h3
  } stack_cmd_e;

  typedef enum logic [1:0]
  {
    T_RAM = 2'h0,
    T_INTERNAL = 2'h1,
    T_PERIPH = 2'h2
  } target_e;
endpackage

// File: logic/ram_if.sv
// carrier between the addressing logic and its RAM array
// assumes both ends share the system clock
`timescale 1ns/1ps
interface ram_if;
  logic en;
  logic we;
  logic [regfile_pkg::RAM_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

// File: logic/register_ram.sv
// linear RAM behind banks 0 to 3, read data registered
// assumes one access per enabled cycle; read during write returns old data
`timescale 1ns/1ps
module register_ram (
  // clock
  input wire logic clock,
  // access port
  ram_if.mem port
);
  logic [7:0] store [0:regfile_pkg::RAM_DEPTH-1];

  always_ff @(posedge clock)
  begin
    if (port.en)
    begin
      if (port.we)
      begin
        store[port.addr] <= port.wdata;
      end
      port.rdata <= store[port.addr];
    end
  end
endmodule

// File: logic/register_file_addressing.sv
// bank/group selection, stack pointer and address decode of the register file
// assumes the core waits for ready; peripheral read data valid the cycle after its request
`timescale 1ns/1ps
module register_file_addressing #(
  parameter bit ram_is_1k = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // nonvolatile configuration
  input wire logic [7:0] option_byte1,
  output logic wide_stack,
  // register access from core
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic reg_short,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic reg_done,
  output logic [7:0] reg_rdata,
  // stack operations from core
  input wire logic stack_req,
  input wire regfile_pkg::stack_cmd_e stack_cmd,
  input wire logic [7:0] stack_wdata,
  input wire logic [15:0] stack_pc,
  input wire logic [7:0] stack_flags,
  output logic stack_done,
  output logic [7:0] stack_rdata,
  // handshake
  output logic ready,
  // selection state
  output logic [3:0] active_bank,
  output logic [3:0] working_group,
  // ports and control registers outside this block
  output logic periph_req,
  output logic periph_write,
  output logic [3:0] periph_bank,
  output logic [7:0] periph_addr,
  output logic [7:0] periph_wdata,
  input wire logic [7:0] periph_rdata
);
  regfile_pkg::seq_state_e state;
  logic mode_loaded, op_stack, op_write, held_last;
  logic [7:0] bank_and_group_select, stack_pointer_high_byte, stack_pointer_low_byte;
  logic [7:0] op_addr, op_wdata, op_flags, held_internal;
  regfile_pkg::stack_cmd_e op_cmd;
  logic [15:0] op_pc;
  logic [1:0] byte_idx;
  regfile_pkg::target_e held_kind;
  ram_if ram_bus ();

  // combinational access decode
  logic [7:0] keep_mask, acc_addr, acc_wdata, acc_internal, capture_data;
  logic [15:0] sp_cur, sp_dec, sp_inc, stack_addr, next_sp;
  logic is_push, acc_write, acc_last, issue, internal_write, take_reg, take_stack;
  logic [3:0] acc_bank, acc_periph_bank;
  regfile_pkg::target_e acc_kind;
  logic [regfile_pkg::RAM_AW-1:0] acc_linear;

  register_ram u_ram (
    .clock(clock),
    .port(ram_bus.mem)
  );

  assign active_bank = bank_and_group_select[3:0];
  assign working_group = bank_and_group_select[7:4];
  assign ready = (state == regfile_pkg::S_IDLE) && mode_loaded;
  assign take_reg = ready && reg_req;
  assign take_stack = ready && stack_req && !reg_req;
  assign issue = (state == regfile_pkg::S_ISSUE);

  // width from option bit
  // caught once after reset release; the option byte is static afterwards
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wide_stack <= 1'b0;
      mode_loaded <= 1'b0;
    end
    else if (!mode_loaded)
    begin
      wide_stack <= option_byte1[regfile_pkg::WIDE_STACK_BIT];
      mode_loaded <= 1'b1;
    end
  end

  always_comb
  begin
    keep_mask = ram_is_1k ? regfile_pkg::SP_HIGH_KEEP_1K : regfile_pkg::SP_HIGH_KEEP_512;
    sp_cur = wide_stack ? {stack_pointer_high_byte & keep_mask, stack_pointer_low_byte}
                        : {8'h00, stack_pointer_low_byte};
    sp_dec = sp_cur - 16'h0001;
    sp_inc = sp_cur + 16'h0001;
    is_push = (op_cmd != regfile_pkg::CMD_POP);
    stack_addr = is_push ? sp_dec : sp_cur;
    next_sp = is_push ? sp_dec : sp_inc;
    unique case (byte_idx)
      2'h0: acc_wdata = (op_cmd == regfile_pkg::CMD_PUSH) ? op_wdata : op_pc[7:0];
      2'h1: acc_wdata = op_pc[15:8];
      default: acc_wdata = op_flags;
    endcase
    if (op_cmd == regfile_pkg::CMD_CALL)
      acc_last = !op_stack || (byte_idx == regfile_pkg::CALL_LAST_BYTE);
    else if (op_cmd == regfile_pkg::CMD_INTR)
      acc_last = !op_stack || (byte_idx == regfile_pkg::INTR_LAST_BYTE);
    else
      acc_last = 1'b1;
    if (op_stack)
    begin
      acc_write = is_push;
      acc_addr = stack_addr[7:0];
      acc_bank = regfile_pkg::BANK_NORMAL;
    end
    else
    begin
      acc_write = op_write;
      acc_addr = op_addr;
      acc_wdata = op_wdata;
      acc_bank = bank_and_group_select[3:0];
    end
    acc_periph_bank = regfile_pkg::BANK_NORMAL;
    acc_linear = {2'h0, acc_addr};
    if (op_stack && wide_stack)
    begin
      // shadows under group F and ports
      acc_kind = regfile_pkg::T_RAM;
      acc_linear = stack_addr[regfile_pkg::RAM_AW-1:0];
    end
    else if (acc_addr[7:4] == regfile_pkg::CONTROL_GROUP)
    begin
      if (acc_addr >= regfile_pkg::GROUP_SELECT_ADDR)
        acc_kind = regfile_pkg::T_INTERNAL;
      else
        acc_kind = regfile_pkg::T_PERIPH;
    end
    else if ((acc_bank == regfile_pkg::BANK_D) || (acc_bank == regfile_pkg::BANK_F))
    begin
      if (acc_addr[7:4] == 4'h0)
      begin
        acc_kind = regfile_pkg::T_PERIPH;
        acc_periph_bank = acc_bank;
      end
      else
        acc_kind = regfile_pkg::T_RAM;
    end
    else if (acc_addr <= regfile_pkg::PORT_LAST_ADDR)
      acc_kind = regfile_pkg::T_PERIPH;
    else
    begin
      // expanded RAM banks
      // reserved banks fall back to bank 0 rather than aliasing a RAM bank
      acc_kind = regfile_pkg::T_RAM;
      if (acc_bank <= regfile_pkg::BANK_LAST_RAM)
        acc_linear = {acc_bank[1:0], acc_addr};
    end
    unique case (acc_addr)
      regfile_pkg::GROUP_SELECT_ADDR: acc_internal = bank_and_group_select;
      regfile_pkg::SP_HIGH_ADDR: acc_internal = stack_pointer_high_byte;
      default: acc_internal = stack_pointer_low_byte;
    endcase
    internal_write = issue && acc_write && (acc_kind == regfile_pkg::T_INTERNAL);
  end

  // sequencer and latched request
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= regfile_pkg::S_IDLE;
      op_stack <= 1'b0;
      op_write <= 1'b0;
      op_addr <= 8'h00;
      op_wdata <= 8'h00;
      op_cmd <= regfile_pkg::CMD_PUSH;
      op_pc <= 16'h0000;
      op_flags <= 8'h00;
      byte_idx <= 2'h0;
    end
    else
    begin
      unique case (state)
        regfile_pkg::S_IDLE:
        begin
          byte_idx <= 2'h0;
          if (take_reg)
          begin
            op_stack <= 1'b0;
            op_write <= reg_write;
            op_addr <= reg_short ? {bank_and_group_select[7:4], reg_addr[3:0]} : reg_addr;
            op_wdata <= reg_wdata;
            state <= regfile_pkg::S_ISSUE;
          end
          else if (take_stack)
          begin
            op_stack <= 1'b1;
            op_cmd <= stack_cmd;
            op_wdata <= stack_wdata;
            op_pc <= stack_pc;
            op_flags <= stack_flags;
            state <= regfile_pkg::S_ISSUE;
          end
        end
        regfile_pkg::S_ISSUE: state <= regfile_pkg::S_WAIT;
        regfile_pkg::S_WAIT: state <= regfile_pkg::S_CAPTURE;
        regfile_pkg::S_CAPTURE:
        begin
          if (held_last)
            state <= regfile_pkg::S_IDLE;
          else
          begin
            byte_idx <= byte_idx + 2'h1;
            state <= regfile_pkg::S_ISSUE;
          end
        end
        default: state <= regfile_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      bank_and_group_select <= regfile_pkg::GROUP_SELECT_RESET;
    else if (internal_write && (acc_addr == regfile_pkg::GROUP_SELECT_ADDR))
      bank_and_group_select <= acc_wdata;
  end

  // stack pointer bytes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stack_pointer_high_byte <= regfile_pkg::SP_HIGH_RESET;
      stack_pointer_low_byte <= regfile_pkg::SP_LOW_RESET;
    end
    else if (issue && op_stack)
    begin
      // no bound check, low byte wraps
      stack_pointer_low_byte <= next_sp[7:0];
      if (wide_stack)
      begin
        stack_pointer_high_byte <= (stack_pointer_high_byte & ~keep_mask) | (next_sp[15:8] & keep_mask);
      end
      else if (internal_write && (acc_addr == regfile_pkg::SP_HIGH_ADDR))
      begin
        stack_pointer_high_byte <= acc_wdata;
      end
    end
    else if (internal_write && (acc_addr == regfile_pkg::SP_HIGH_ADDR))
      stack_pointer_high_byte <= acc_wdata;
    else if (internal_write && (acc_addr == regfile_pkg::SP_LOW_ADDR))
      stack_pointer_low_byte <= acc_wdata;
  end

  // registered access to RAM and outside registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ram_bus.en <= 1'b0;
      ram_bus.we <= 1'b0;
      ram_bus.addr <= '0;
      ram_bus.wdata <= 8'h00;
      periph_req <= 1'b0;
      periph_write <= 1'b0;
      periph_bank <= 4'h0;
      periph_addr <= 8'h00;
      periph_wdata <= 8'h00;
      held_kind <= regfile_pkg::T_RAM;
      held_internal <= 8'h00;
      held_last <= 1'b0;
    end
    else
    begin
      ram_bus.en <= issue && (acc_kind == regfile_pkg::T_RAM);
      periph_req <= issue && (acc_kind == regfile_pkg::T_PERIPH);
      if (issue)
      begin
        ram_bus.we <= acc_write;
        ram_bus.addr <= acc_linear;
        ram_bus.wdata <= acc_wdata;
        periph_write <= acc_write;
        periph_bank <= acc_periph_bank;
        periph_addr <= acc_addr;
        periph_wdata <= acc_wdata;
        held_kind <= acc_kind;
        held_internal <= acc_internal;
        held_last <= acc_last;
      end
    end
  end

  always_comb
  begin
    unique case (held_kind)
      regfile_pkg::T_INTERNAL: capture_data = held_internal;
      regfile_pkg::T_PERIPH: capture_data = periph_rdata;
      default: capture_data = ram_bus.rdata;
    endcase
  end

  // answers to the core
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_done <= 1'b0;
      stack_done <= 1'b0;
      reg_rdata <= 8'h00;
      stack_rdata <= 8'h00;
    end
    else
    begin
      reg_done <= (state == regfile_pkg::S_CAPTURE) && !op_stack;
      stack_done <= (state == regfile_pkg::S_CAPTURE) && op_stack && held_last;
      if ((state == regfile_pkg::S_CAPTURE) && !op_stack && !op_write)
        reg_rdata <= capture_data;
      if ((state == regfile_pkg::S_CAPTURE) && op_stack && (op_cmd == regfile_pkg::CMD_POP))
        stack_rdata <= capture_data;
    end
  end
endmodule

// File: sim/periph_model.sv
// port and control register responder beside the addressing block
// assumes read data is wanted only in the cycle right after a request
`timescale 1ns/1ps
module periph_model (
  // clock
  input wire logic clock,
  // request from the addressing block
  input wire logic periph_req,
  input wire logic periph_write,
  input wire logic [3:0] periph_bank,
  input wire logic [7:0] periph_addr,
  input wire logic [7:0] periph_wdata,
  // answer
  output logic [7:0] periph_rdata
);
  logic [7:0] store [4096] = '{default: 8'h00};
  initial
    periph_rdata = 8'h00;
  // data holds one cycle only; toggling after that exposes a late sample
  always @(posedge clock)
    if (periph_req)
    begin
      if (periph_write)
        store[{periph_bank, periph_addr}] <= periph_wdata;
      periph_rdata <= store[{periph_bank, periph_addr}];
    end
    else
      periph_rdata <= ~periph_rdata;
endmodule

// File: sim/register_file_addressing_sva.sv
// port assertions for the register file addressing block
// assumes one system clock and the synchronous active-high reset
`timescale 1ns/1ps
module register_file_addressing_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // core side
  input wire logic [7:0] option_byte1,
  input wire logic wide_stack,
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic reg_short,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_done,
  input wire logic stack_req,
  input wire regfile_pkg::stack_cmd_e stack_cmd,
  input wire logic stack_done,
  input wire logic ready,
  input wire logic [3:0] active_bank,
  input wire logic [3:0] working_group,
  // far side
  input wire logic periph_req,
  input wire logic [3:0] periph_bank,
  input wire logic [7:0] periph_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic reg_take = ready && reg_req;
  wire logic stk_take = ready && !reg_req && stack_req;
  a_option_latch: assert property (
    $fell(rst) |=> wide_stack == $past(option_byte1[regfile_pkg::WIDE_STACK_BIT]))
    else $error("stack width not taken from option bit");
  a_reg_timing: assert property (
    reg_take |=> !ready[*3] ##1 (reg_done && ready))
    else $error("register access timing wrong");
  a_byte_timing: assert property (
    stk_take && stack_cmd inside {regfile_pkg::CMD_PUSH, regfile_pkg::CMD_POP} |-> ##4 stack_done)
    else $error("push or pop timing wrong");
  a_call_two_bytes: assert property (
    stk_take && stack_cmd == regfile_pkg::CMD_CALL |=> !stack_done[*6] ##1 stack_done)
    else $error("call does not store two bytes");
  a_intr_three_bytes: assert property (
    stk_take && stack_cmd == regfile_pkg::CMD_INTR |-> ##10 (stack_done && !$past(ready)))
    else $error("interrupt does not store three bytes");
  a_pointer_write: assert property (
    reg_take && reg_write && !reg_short && reg_addr == regfile_pkg::GROUP_SELECT_ADDR
    |-> ##4 {working_group, active_bank} == $past(reg_wdata, 4))
    else $error("bank and group select not updated");
  a_control_bank0: assert property (
    reg_take && !reg_short && reg_addr >= 8'hF0 && reg_addr <= 8'hFC
    |-> ##2 periph_req && periph_bank == regfile_pkg::BANK_NORMAL && periph_addr == $past(reg_addr, 2))
    else $error("control access left bank 0");
  a_bank_swap: assert property (
    reg_take && !reg_short && active_bank == regfile_pkg::BANK_D && reg_addr < 8'h10
    |-> ##2 periph_req && periph_bank == regfile_pkg::BANK_D && periph_addr == $past(reg_addr, 2))
    else $error("low sixteen not swapped to bank");
  a_wide_shadow: assert property (
    stk_take && wide_stack |=> !periph_req[*3])
    else $error("wide stack reached a port");
  a_narrow_bank0: assert property (
    stk_take && !wide_stack |=> ##1 (!periph_req || periph_bank == regfile_pkg::BANK_NORMAL))
    else $error("narrow stack left bank 0");
endmodule
bind register_file_addressing register_file_addressing_sva chk (.clock, .rst, .option_byte1, .wide_stack,
  .reg_req, .reg_write, .reg_short, .reg_addr, .reg_wdata, .reg_done, .stack_req, .stack_cmd, .stack_done,
  .ready, .active_bank, .working_group, .periph_req, .periph_bank, .periph_addr);

// File: sim/tb.sv
// self-checking bench: integer model of the register file against the block
// assumes the peripheral responder model and the bound checker
`timescale 1ns/1ps
module tb;
  localparam int IR = 9000;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] option_byte1 = 8'h00;
  logic reg_req = 1'b0;
  logic reg_write = 1'b0;
  logic reg_short = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic stack_req = 1'b0;
  regfile_pkg::stack_cmd_e stack_cmd = regfile_pkg::CMD_PUSH;
  logic [7:0] stack_wdata = 8'h00;
  logic [15:0] stack_pc = 16'h0000;
  logic [7:0] stack_flags = 8'h00;
  logic wide_stack, reg_done, stack_done, ready, periph_req, periph_write;
  logic [7:0] reg_rdata, stack_rdata, periph_addr, periph_wdata, periph_rdata;
  logic [3:0] active_bank, working_group, periph_bank;
  logic [15:0] lf = 16'hFE28;
  logic [3:0] banks [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hD, 4'hE, 4'hF};
  logic [7:0] addrs [8] = '{8'h00, 8'h02, 8'h0A, 8'h10, 8'h80, 8'hEF, 8'hF5, 8'hFC};
  int mem [10000] = '{default: 0};
  int failures = 0;
  int checked = 0;
  always #25 clock = ~clock;
  register_file_addressing uut (.clock, .rst, .option_byte1, .wide_stack, .reg_req, .reg_write, .reg_short,
    .reg_addr, .reg_wdata, .reg_done, .reg_rdata, .stack_req, .stack_cmd, .stack_wdata, .stack_pc, .stack_flags,
    .stack_done, .stack_rdata, .ready, .active_bank, .working_group, .periph_req, .periph_write, .periph_bank,
    .periph_addr, .periph_wdata, .periph_rdata);
  periph_model far (.clock, .periph_req, .periph_write, .periph_bank, .periph_addr, .periph_wdata, .periph_rdata);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // codes: below 1024 ram, 4096 up ports, IR up internal
  function automatic int dec(input int a, input int b);
    if (a >= 253)
      return IR + a;
    if (a >= 240)
      return 4096 + a;
    if (b == 13 || b == 15)
      return a < 16 ? 4096 + b * 256 + a : a;
    if (a <= 3)
      return 4096 + a;
    return b <= 3 ? b * 256 + a : a;
  endfunction
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  task automatic op(input bit stk, input bit w, input bit s, input logic [7:0] a, input logic [7:0] d,
                    input int cmd, output logic [7:0] q);
    int n;
    reg_req = !stk;
    stack_req = stk;
    reg_write = w;
    reg_short = s;
    reg_addr = a;
    reg_wdata = d;
    stack_wdata = d;
    stack_pc = {rnd(), rnd()};
    stack_flags = rnd();
    stack_cmd = regfile_pkg::stack_cmd_e'(cmd);
    n = 0;
    while (ready !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #2;
      n++;
    end
    check(16'(n >= 20), 16'h0000);
    @(posedge clock);
    #2;
    reg_req = 1'b0;
    stack_req = 1'b0;
    n = 0;
    while ((stk ? stack_done : reg_done) !== 1'b1 && n < 40)
    begin
      @(posedge clock);
      #2;
      n++;
    end
    check(16'(n >= 40), 16'h0000);
    q = stk ? stack_rdata : reg_rdata;
  endtask
  task automatic reg_acc(input bit w, input bit s, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    int rp;
    int c;
    rp = mem[IR + 253];
    c = dec(s ? (rp & 240) + int'(a[3:0]) : int'(a), rp & 15);
    op(1'b0, w, s, a, d, 0, q);
    if (w)
      mem[c] = d;
    else
      check({8'h00, q}, 16'(mem[c]));
    check({8'h00, working_group, active_bank}, 16'(mem[IR + 253]));
  endtask
  task automatic push(input int d);
    int p;
    if (wide_stack)
    begin
      p = ((mem[IR + 254] & 3) * 256 + mem[IR + 255] - 1) & 65535;
      mem[IR + 254] = (mem[IR + 254] & 252) | ((p >> 8) & 3);
      mem[IR + 255] = p & 255;
      mem[p & 1023] = d;
    end
    else
    begin
      mem[IR + 255] = (mem[IR + 255] + 255) & 255;
      p = dec(mem[IR + 255], 0);
      if (p != IR + 255)
        mem[p] = d;
    end
  endtask
  task automatic pop(output int q);
    int p;
    if (wide_stack)
    begin
      p = (mem[IR + 254] & 3) * 256 + mem[IR + 255];
      q = mem[p];
      p = (p + 1) & 1023;
      mem[IR + 254] = (mem[IR + 254] & 252) | (p >> 8);
      mem[IR + 255] = p & 255;
    end
    else
    begin
      q = mem[dec(mem[IR + 255], 0)];
      mem[IR + 255] = (mem[IR + 255] + 1) & 255;
    end
  endtask
  task automatic stk(input int cmd);
    logic [7:0] q;
    int e;
    op(1'b1, 1'b0, 1'b0, 8'h00, rnd(), cmd, q);
    if (cmd == 1)
    begin
      pop(e);
      check({8'h00, q}, 16'(e));
    end
    else if (cmd == 0)
      push(stack_wdata);
    else
    begin
      push(stack_pc[7:0]);
      push(stack_pc[15:8]);
      if (cmd == 3)
        push(stack_flags);
    end
  endtask
  task automatic restart(input logic [7:0] opt);
    rst = 1'b1;
    option_byte1 = opt;
    repeat (4) @(posedge clock);
    #2;
    rst = 1'b0;
    mem[IR + 253] = 0;
    mem[IR + 254] = 0;
    mem[IR + 255] = 0;
    @(posedge clock);
    #2;
    check({15'h0000, wide_stack}, {15'h0000, opt[3]});
  endtask
  initial
  begin
    #3000000;
    failures++;
    summarize();
  end
  initial
  begin
    logic [7:0] d;
    restart(8'h00);
    for (int a = 253; a < 256; a++)
      reg_acc(1'b0, 1'b0, 8'(a), 8'h00);
    foreach (banks[i])
    begin
      d = rnd();
      reg_acc(1'b1, 1'b0, 8'hFD, {d[7:4], banks[i]});
      foreach (addrs[j])
      begin
        reg_acc(1'b1, 1'b0, addrs[j], rnd());
        reg_acc(1'b0, 1'b0, addrs[j], 8'h00);
        reg_acc(1'b1, 1'b1, addrs[j], rnd());
        reg_acc(1'b0, 1'b1, addrs[j], 8'h00);
      end
    end
    // narrow stack in bank 0 while bank 2 active
    reg_acc(1'b1, 1'b0, 8'hFD, 8'h72);
    reg_acc(1'b1, 1'b0, 8'hFE, 8'h5A);
    reg_acc(1'b1, 1'b0, 8'hFF, 8'h90);
    for (int k = 0; k < 4; k++)
      stk(k);
    reg_acc(1'b1, 1'b0, 8'hFD, 8'h00);
    for (int a = 139; a < 144; a++)
      reg_acc(1'b0, 1'b0, 8'(a), 8'h00);
    reg_acc(1'b0, 1'b0, 8'hFF, 8'h00);
    repeat (5) stk(1);
    // low byte wraps, high byte kept
    reg_acc(1'b1, 1'b0, 8'hFF, 8'h01);
    stk(0);
    stk(0);
    reg_acc(1'b0, 1'b0, 8'hFF, 8'h00);
    reg_acc(1'b0, 1'b0, 8'hFE, 8'h00);
    restart(8'h08);
    // group F shadow of bank 0
    reg_acc(1'b1, 1'b0, 8'hFE, 8'h01);
    reg_acc(1'b1, 1'b0, 8'hFF, 8'h00);
    stk(0);
    stk(1);
    // masked high byte, wrap into bank 3
    reg_acc(1'b1, 1'b0, 8'hFE, 8'hFC);
    reg_acc(1'b1, 1'b0, 8'hFF, 8'h02);
    stk(3);
    stk(2);
    reg_acc(1'b0, 1'b0, 8'hFE, 8'h00);
    reg_acc(1'b0, 1'b0, 8'hFF, 8'h00);
    reg_acc(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (5) stk(1);
    summarize();
  end
endmodule
